// File: rtl/ftbs_port.sv
// Flow-through burst memory port with its storage array
`timescale 1ns/1ps
`include "ftbs_defines.svh"

module ftbs_port
(
	input  wire logic                        clk_sys,
	input  wire logic                        rst_n,
	input  wire logic [`FTBS_ADDR_W-1:0]     addr,
	input  wire logic                        chip_select_first_low,
	input  wire logic                        chip_select_second_high,
	input  wire logic                        chip_select_third_low,
	input  wire logic                        processor_addr_strobe_n,
	input  wire logic                        controller_addr_strobe_n,
	input  wire logic                        burst_advance_n,
	input  wire logic                        byte_write_gate_n,
	input  wire logic [`FTBS_LANES-1:0]      byte_lane_select_n,
	input  wire logic                        global_write_n,
	input  wire logic                        output_enable_n,
	input  wire logic                        burst_order,
	input  wire logic                        sleep_request,
	input  wire logic [`FTBS_DATA_W-1:0]     data_in,
	input  wire logic [`FTBS_LANES-1:0]      parity_in,
	output      logic [`FTBS_DATA_W-1:0]     data_out,
	output      logic [`FTBS_LANES-1:0]      parity_out,
	output      logic                        data_oe,
	output      ftbs_pkg::ftbs_sleep_t       sleep_state
);
	import ftbs_pkg::*;

	// Flow-through port: a read word leaves on the same edge that takes
	// its address, and a write lands on that edge too, except on a processor-started load, which ignores the write inputs.
	// Sleep drops every access and leaves the port deselected, so the
	// controller has to load a fresh address once it is awake again.
	// Data and parity travel as separate in and out ports plus an enable.

	// ************************************************************
	// Declarations
	// ************************************************************
	// Captured address, burst state and select
	logic [`FTBS_ADDR_W-1:0]  base_q;
	logic [`FTBS_BURST_W-1:0] start_q;
	logic [`FTBS_BURST_W-1:0] count_q;
	logic                     selected_q;
	logic                     was_desel_q;

	// Synchronised pins, strap capture and sleep sequencing
	logic [1:0]               oe_sync_q;
	logic [1:0]               sleep_sync_q;
	logic [1:0]               order_sync_q;
	logic [1:0]               order_age_q;
	logic                     order_loaded_q;
	ftbs_order_t              order_q;
	ftbs_sleep_t              sleep_q;
	logic [`FTBS_SLEEP_CYC-1:0] sleep_cnt_q;

	// Output flops, one group per pin set
	logic [`FTBS_DATA_W-1:0]  dout_q;
	logic [`FTBS_LANES-1:0]   pout_q;
	logic                     oe_q;

	// Decode for the edge now being taken
	logic                     awake;
	logic                     cs_ok;
	logic                     proc_load;
	logic                     ctrl_load;
	logic                     load;
	logic                     sel_d;
	logic [`FTBS_BURST_W-1:0] start_d;
	logic [`FTBS_BURST_W-1:0] count_d;
	logic [`FTBS_ADDR_W-1:0]  base_d;
	logic [`FTBS_ADDR_W-1:0]  eff_addr;
	logic [`FTBS_LANES-1:0]   lane_we;
	logic                     write_req;
	logic                     write_now;
	logic                     read_now;

	// ************************************************************
	// Helpers
	// ************************************************************

	// Burst address from start bits and step count. Keeping the start
	// and a step count lets both orders share one two-bit counter.
	function automatic logic [`FTBS_BURST_W-1:0] burst_bits
	(
		input ftbs_order_t              order,
		input logic [`FTBS_BURST_W-1:0] start,
		input logic [`FTBS_BURST_W-1:0] count
	);
		logic [`FTBS_BURST_W-1:0] r;
		r = start ^ count;
		if (order == FTBS_LINEAR)
			r = start + count;                   // Wraps mod four
		return r;
	endfunction

	// ************************************************************
	// Input synchronisers
	// ************************************************************

	// Output enable, sleep and strap arrive off the clock; two stages each.
	// Cost: output enable takes effect a few cycles late, not at once.
	// Reset values are the idle levels, so no false request follows.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			oe_sync_q    <= 2'h3;
			sleep_sync_q <= 2'h0;
			order_sync_q <= 2'h3;
		end
		else
		begin
			oe_sync_q    <= {oe_sync_q[0], output_enable_n};
			sleep_sync_q <= {sleep_sync_q[0], sleep_request};
			order_sync_q <= {order_sync_q[0], burst_order};
		end
	end

	// Strap is caught once, on the third edge after reset release, when
	// the synchroniser holds the pin's own level; later changes ignored
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			order_age_q    <= 2'h0;
			order_loaded_q <= 1'h0;
			order_q        <= FTBS_INTERLEAVE;
		end
		else if (!order_loaded_q)
		begin
			if (order_age_q == `FTBS_STRAP_WAIT)
			begin
				order_loaded_q <= 1'h1;
				// Low is linear, high interleaved
				order_q <= (order_sync_q[1] == `FTBS_ORDER_LIN) ?
					FTBS_LINEAR : FTBS_INTERLEAVE;
			end
			else
				order_age_q <= order_age_q + 2'h1;
		end
	end

	// ************************************************************
	// Sleep sequencing
	// ************************************************************

	// Two cycles to enter and to leave; the array keeps its contents.
	// Accesses pending at entry are dropped and the port wakes up
	// deselected, so the controller must load a fresh address.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sleep_q     <= FTBS_AWAKE;
			sleep_cnt_q <= '0;
		end
		else
		begin
			case (sleep_q)
				FTBS_AWAKE:
					if (sleep_sync_q[1])
					begin
						sleep_q     <= FTBS_ENTER;
						sleep_cnt_q <= '0;
					end
				FTBS_ENTER:
					if (sleep_cnt_q == `FTBS_SLEEP_CYC'(`FTBS_SLEEP_CYC - 1))
						sleep_q <= FTBS_ASLEEP;
					else
						sleep_cnt_q <= sleep_cnt_q + 1'h1;
				FTBS_ASLEEP:
					if (!sleep_sync_q[1])
					begin
						sleep_q     <= FTBS_EXIT;
						sleep_cnt_q <= '0;
					end
				FTBS_EXIT:
					if (sleep_cnt_q == `FTBS_SLEEP_CYC'(`FTBS_SLEEP_CYC - 1))
						sleep_q <= FTBS_AWAKE;
					else
						sleep_cnt_q <= sleep_cnt_q + 1'h1;
				default:
					sleep_q <= FTBS_AWAKE;
			endcase
		end
	end

	assign awake = (sleep_q == FTBS_AWAKE);

	// ************************************************************
	// Access decode
	// ************************************************************

	// All three selects must agree
	// A wrong select on a load deselects; it does not keep the old burst
	assign cs_ok = !chip_select_first_low && chip_select_second_high &&
		!chip_select_third_low;

	// Processor strobe counts only with first select low
	assign proc_load = !processor_addr_strobe_n && !chip_select_first_low;
	// Controller strobe acts unless the processor strobe loads; with the
	// first select high the processor strobe counts as absent
	assign ctrl_load = !controller_addr_strobe_n && !proc_load;
	assign load      = awake && (proc_load || ctrl_load);

	// Write kind and lane mask
	// Global write overrides the byte gate and both lane selects
	always_comb
	begin
		lane_we = '0;
		if (!global_write_n)
			lane_we = '1;
		else if (!byte_write_gate_n)
			lane_we = ~byte_lane_select_n;           // Lane 0 low
	end
	assign write_req = |lane_we;

	// Next address, select and burst state
	// Selects count only on a load; a burst carries the old select
	always_comb
	begin
		sel_d   = selected_q;
		base_d  = base_q;
		start_d = start_q;
		count_d = count_q;
		if (!awake)
			sel_d = 1'h0;
		else if (load)
		begin
			sel_d   = cs_ok;                         // Selects looked at here
			base_d  = addr;
			start_d = addr[`FTBS_BURST_W-1:0];
			count_d = '0;
		end
		else if (selected_q && !burst_advance_n)
			count_d = count_q + 1'h1;                // Two-bit wrap
		eff_addr = {base_d[`FTBS_ADDR_W-1:`FTBS_BURST_W],
			burst_bits(order_q, start_d, count_d)};
	end

	// Processor-started access ignores the write inputs in its first cycle
	assign write_now = sel_d && write_req && !(load && proc_load);
	assign read_now  = sel_d && !write_now;

	// ************************************************************
	// Input and burst registers
	// ************************************************************

	// Address, selects and strobe decisions land on the rising edge
	// Only the decode result is kept; the raw pins are not stored twice
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			base_q     <= '0;
			start_q    <= '0;
			count_q    <= '0;
			selected_q <= 1'h0;
		end
		else
		begin
			base_q     <= base_d;
			start_q    <= start_d;
			count_q    <= count_d;
			selected_q <= sel_d;
		end
	end

	// Note a deselected cycle; the read after it keeps the pins quiet
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			was_desel_q <= 1'h1;
		end
		else
		begin
			was_desel_q <= !sel_d;
		end
	end

	// ************************************************************
	// Storage array
	// ************************************************************

	// One lane per byte plus its parity bit. Each lane keeps an array of
	// its own, so no two processes ever write one variable. Contents are
	// not reset: a read before any write returns whatever is stored.
	for (genvar i = 0; i < `FTBS_LANES; i++)
	begin : g_lane
		logic [`FTBS_LANE_W-1:0] lane_mem [0:`FTBS_DEPTH-1];

		// Pin data captured straight into the array
		always_ff @(posedge clk_sys)
		begin
			if (write_now && lane_we[i])
				lane_mem[eff_addr] <=
					{parity_in[i],
					data_in[i*`FTBS_BYTE_W +: `FTBS_BYTE_W]};
		end

		// Read data is the word at the address just taken; no extra
		// stage, so it leaves on the edge that takes the address
		always_ff @(posedge clk_sys or negedge rst_n)
		begin
			if (!rst_n)
			begin
				dout_q[i*`FTBS_BYTE_W +: `FTBS_BYTE_W] <= '0;
				pout_q[i]                              <= 1'h0;
			end
			else if (read_now)
			begin
				dout_q[i*`FTBS_BYTE_W +: `FTBS_BYTE_W] <=
					lane_mem[eff_addr][`FTBS_BYTE_W-1:0];
				pout_q[i] <= lane_mem[eff_addr][`FTBS_BYTE_W];
			end
		end
	end

	// ************************************************************
	// Output drive
	// ************************************************************

	// Drive only on a read with output enable low, never on writes,
	// never while asleep, and not in the first read after deselect.
	// Registered, so the enable cannot glitch between two reads; the
	// output enable pin is read through its synchroniser, never raw.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			oe_q <= 1'h0;
		else
			oe_q <= read_now && awake && !oe_sync_q[1] &&
				!write_now &&
				!(was_desel_q && load);
	end

	// Every output is a flop; these only rename them
	assign data_out    = dout_q;
	assign parity_out  = pout_q;
	assign data_oe     = oe_q;
	assign sleep_state = sleep_q;

endmodule

// File: rtl/ftbs_defines.svh
// Constants for the flow-through burst memory port
// ****************************************************************
// ****************************************************************
`ifndef FTBS_DEFINES_SVH
`define FTBS_DEFINES_SVH

`define FTBS_ADDR_W      17
`define FTBS_DATA_W      16
`define FTBS_LANES       2
`define FTBS_BYTE_W      8
`define FTBS_LANE_W      9
`define FTBS_WORD_W      18
`define FTBS_BURST_W     2
`define FTBS_DEPTH       131072
`define FTBS_SLEEP_CYC   2
`define FTBS_ORDER_LIN   1'h0
`define FTBS_STRAP_WAIT  2'h2

`endif

// File: rtl/ftbs_pkg.sv
// Types shared by the flow-through burst memory port
package ftbs_pkg;

	// Sleep sequencing, one-hot
	typedef enum logic [3:0]
	{
		FTBS_AWAKE  = 4'h1,
		FTBS_ENTER  = 4'h2,
		FTBS_ASLEEP = 4'h4,
		FTBS_EXIT   = 4'h8
	} ftbs_sleep_t;

	// Burst address order
	typedef enum logic
	{
		FTBS_LINEAR     = 1'h0,
		FTBS_INTERLEAVE = 1'h1
	} ftbs_order_t;

endpackage

// File: verification/ftbs_port_properties.sv
// Concurrent checks on the memory port's pins
`timescale 1ns/1ps
module ftbs_port_checker
(
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic        chip_select_first_low,
	input wire logic        chip_select_second_high,
	input wire logic        chip_select_third_low,
	input wire logic        processor_addr_strobe_n,
	input wire logic        controller_addr_strobe_n,
	input wire logic        byte_write_gate_n,
	input wire logic [1:0]  byte_lane_select_n,
	input wire logic        global_write_n,
	input wire logic        output_enable_n,
	input wire logic        sleep_request,
	input wire logic        data_oe,
	input ftbs_pkg::ftbs_sleep_t sleep_state
);
	import ftbs_pkg::*;
	// ****************************************************************
	// Pin relations
	// ****************************************************************
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	// Controller strobe with at least one select wrong
	sequence s_bad_select;
		!controller_addr_strobe_n && processor_addr_strobe_n &&
		(chip_select_first_low || !chip_select_second_high ||
		chip_select_third_low);
	endsequence
	// Processor load with the first select right
	sequence s_proc_load;
		!processor_addr_strobe_n && !chip_select_first_low;
	endsequence
	// Entry and exit each dwell two samples in transit
	sequence s_enter;
		(sleep_state == FTBS_ENTER)[*2] ##1 sleep_state == FTBS_ASLEEP;
	endsequence
	sequence s_exit;
		(sleep_state == FTBS_EXIT)[*2] ##1 sleep_state == FTBS_AWAKE;
	endsequence
	AST_DESELECT_FLOATS: assert property
		(s_bad_select |=> !data_oe) else $error("driven while deselected");
	AST_FIRST_READ_MASKED: assert property
		(s_bad_select ##1 s_proc_load |=> !data_oe)
		else $error("first read after deselect drove the bus");
	AST_GLOBAL_WRITE_FLOATS: assert property
		(processor_addr_strobe_n && !global_write_n |=> !data_oe)
		else $error("bus driven during a global write");
	AST_BYTE_WRITE_FLOATS: assert property
		(processor_addr_strobe_n && !byte_write_gate_n &&
		byte_lane_select_n != 2'h3 |=> !data_oe)
		else $error("bus driven during a byte write");
	AST_OE_HIGH_FLOATS: assert property
		(output_enable_n[*5] |-> !data_oe)
		else $error("bus driven with output enable high");
	AST_ASLEEP_FLOATS: assert property
		(sleep_state == FTBS_ASLEEP |-> !data_oe)
		else $error("bus driven while asleep");
	AST_SLEEP_RESPONDS: assert property
		($rose(sleep_request) && sleep_state == FTBS_AWAKE
		|-> ##[1:5] sleep_state == FTBS_ENTER)
		else $error("sleep request not taken");
	AST_SLEEP_ENTRY: assert property
		($rose(sleep_state == FTBS_ENTER) |-> s_enter)
		else $error("sleep entry length wrong");
	AST_SLEEP_EXIT: assert property
		($rose(sleep_state == FTBS_EXIT) |-> s_exit)
		else $error("sleep exit length wrong");
endmodule

// File: verification/ftbs_host_model.sv
// Controller model that drives the memory port's synchronous pins
`timescale 1ns/1ps
module ftbs_host_model
(
	input  wire logic   clk_sys,
	output logic [16:0] addr,
	output logic        chip_select_first_low,
	output logic        chip_select_second_high,
	output logic        chip_select_third_low,
	output logic        processor_addr_strobe_n,
	output logic        controller_addr_strobe_n,
	output logic        burst_advance_n,
	output logic        byte_write_gate_n,
	output logic [1:0]  byte_lane_select_n,
	output logic        global_write_n,
	output logic        output_enable_n,
	output logic        sleep_request,
	output logic [15:0] data_in,
	output logic [1:0]  parity_in
);
	// ****************************************************************
	// Pin drivers
	// ****************************************************************
	// Idle bus at time zero: strobes off, no write, sleep low
	initial
	begin
		{processor_addr_strobe_n, controller_addr_strobe_n} = 2'h3;
		{global_write_n, byte_write_gate_n, byte_lane_select_n} = 4'hf;
		{burst_advance_n, output_enable_n, sleep_request} = 3'h4;
		{chip_select_first_low, chip_select_second_high,
			chip_select_third_low} = 3'h2;
		{addr, parity_in, data_in} = '0;
	end
	// One bus cycle: pins change just after an edge, held to the next
	task automatic cyc(input logic p, c, input logic [2:0] s,
		input logic v, input logic [16:0] a, input logic [3:0] w,
		input logic [17:0] d);
		{processor_addr_strobe_n, controller_addr_strobe_n} = {p, c};
		{chip_select_first_low, chip_select_second_high,
			chip_select_third_low} = s;
		burst_advance_n = v;
		addr = a;
		{global_write_n, byte_write_gate_n, byte_lane_select_n} = w;
		// Unused data lines toggle so a stale value never looks valid
		{parity_in, data_in} = (w == 4'hf) ? ~{parity_in, data_in} : d;
		@(posedge clk_sys);
		#1;
	endtask
	// Asynchronous levels; sleep is raised only after a deselect
	task automatic pins(input logic o, z);
		output_enable_n = o;
		sleep_request = z;
	endtask
endmodule

// File: verification/tb.sv
// Self-checking bench for the flow-through burst memory port
`timescale 1ns/1ps
module tb;
	import ftbs_pkg::*;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic        burst_order = 1'b1;
	logic [16:0] addr;
	logic [15:0] data_in, data_out;
	logic [1:0]  parity_in, parity_out, byte_lane_select_n;
	logic        chip_select_first_low, chip_select_second_high;
	logic        chip_select_third_low, processor_addr_strobe_n;
	logic        controller_addr_strobe_n, burst_advance_n;
	logic        byte_write_gate_n, global_write_n, output_enable_n;
	logic        sleep_request, data_oe;
	ftbs_sleep_t sleep_state;
	int          miscompares = 0;
	int          checks = 0;
	// ****************************************************************
	// Harness and checks
	// ****************************************************************
	ftbs_port u_dut(.clk_sys, .rst_n, .addr, .chip_select_first_low,
		.chip_select_second_high, .chip_select_third_low,
		.processor_addr_strobe_n, .controller_addr_strobe_n,
		.burst_advance_n, .byte_write_gate_n, .byte_lane_select_n,
		.global_write_n, .output_enable_n, .burst_order, .sleep_request,
		.data_in, .parity_in, .data_out, .parity_out, .data_oe,
		.sleep_state);
	ftbs_host_model u_h(.clk_sys, .addr, .chip_select_first_low,
		.chip_select_second_high, .chip_select_third_low,
		.processor_addr_strobe_n, .controller_addr_strobe_n,
		.burst_advance_n, .byte_write_gate_n, .byte_lane_select_n,
		.global_write_n, .output_enable_n, .sleep_request, .data_in,
		.parity_in);
	// 40 MHz system clock
	always #12.5 clk_sys = ~clk_sys;
	// Word stored at each address, parity from the low bits
	function automatic logic [17:0] pat(input logic [16:0] a);
		return {a[1:0], a[7:0] ^ 8'h5a, a[7:0]};
	endfunction
	task automatic chk(input logic [17:0] seen, exp);
		checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: %h not %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d, miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Idle until the sleep state shows, bounded
	task automatic wait_state(input ftbs_sleep_t s);
		int n;
		for (n = 0; n < 20 && sleep_state !== s; n++)
			u_h.cyc(1, 1, 3'h0, 1, '0, 4'hf, '0);
		chk(sleep_state, s);
		if (sleep_state !== s)
			tally_and_finish();
	endtask
	// Writes, a four-beat burst, strobe corner cases, byte write
	task automatic run_order(input logic o);
		logic [16:0] b;
		logic [16:0] e;
		b = o ? 17'h100 : 17'h200;
		for (int i = 0; i < 4; i++)
		begin
			u_h.cyc(1, 0, 3'h2, 1, b + i, 4'h7, pat(b + i));
			chk(data_oe, 0);
		end
		u_h.cyc(1, 0, 3'h0, 1, b, 4'hf, '0);
		chk(data_oe, 0);
		u_h.cyc(0, 1, 3'h2, 1, b + 1, 4'hf, '0);
		chk(data_oe, 0);
		chk({parity_out, data_out}, pat(b + 1));
		for (int k = 1; k < 4; k++)
		begin
			// Selects wrong on purpose: ignored while continuing
			u_h.cyc(1, 1, 3'h5, 0, '0, 4'hf, '0);
			e = {b[16:2], o ? 2'h1 ^ k[1:0] : 2'h1 + k[1:0]};
			chk({parity_out, data_out}, pat(e));
			chk(data_oe, 1);
		end
		u_h.cyc(0, 0, 3'h6, 1, b + 3, 4'hf, '0);
		chk({parity_out, data_out}, pat(e));
		chk(data_oe, 0);
		u_h.cyc(0, 0, 3'h2, 1, b + 3, 4'h7, '0);
		chk({parity_out, data_out}, pat(b + 3));
		chk(data_oe, 0);
		u_h.cyc(0, 1, 3'h2, 1, b, 4'hf, '0);
		chk({parity_out, data_out}, pat(b));
		chk(data_oe, 1);
		u_h.cyc(1, 1, 3'h2, 1, '0, 4'ha, '0);
		chk(data_oe, 0);
		u_h.cyc(1, 1, 3'h2, 1, '0, 4'hf, '0);
		chk({parity_out, data_out}, pat(b) & 18'h2ff00);
		u_h.pins(1, 0);
		repeat (5) u_h.cyc(1, 1, 3'h2, 1, '0, 4'hf, '0);
		chk(data_oe, 0);
		u_h.pins(0, 0);
		repeat (4) u_h.cyc(1, 1, 3'h2, 1, '0, 4'hf, '0);
		chk(data_oe, 1);
	endtask
	// Both strap settings, each from a fresh reset, then sleep
	initial
	begin
		for (int o = 1; o >= 0; o--)
		begin
			rst_n = 1'b0;
			burst_order = o[0];
			repeat (20) @(posedge clk_sys);
			#1;
			rst_n = 1'b1;
			repeat (4) @(posedge clk_sys);
			#1;
			run_order(o[0]);
		end
		u_h.cyc(1, 0, 3'h0, 1, '0, 4'hf, '0);
		u_h.pins(0, 1);
		wait_state(FTBS_ASLEEP);
		chk(data_oe, 0);
		u_h.pins(0, 0);
		wait_state(FTBS_AWAKE);
		u_h.cyc(1, 0, 3'h2, 1, 17'h201, 4'hf, '0);
		chk({parity_out, data_out}, pat(17'h201));
		tally_and_finish();
	end
endmodule

bind ftbs_port ftbs_port_checker u_chk(.clk_sys, .rst_n,
	.chip_select_first_low, .chip_select_second_high,
	.chip_select_third_low, .processor_addr_strobe_n,
	.controller_addr_strobe_n, .byte_write_gate_n, .byte_lane_select_n,
	.global_write_n, .output_enable_n, .sleep_request, .data_oe,
	.sleep_state);
